// ### hw/pagam_port_a.sv
// Purpose: 8-bit port A with direction, latch, analog select, osc pins
// Assumes: clk is the oscillator clock, APB slave, no waits while ce stays high through the transfer
// Notes:   pin drive lags register state by one cycle
//
// Notes on behaviour
// R01: direction one floats pin as input; zero drives latch onto it
// R02: pin register reads pin levels; writes go to the output latch
// R03: latch register reads back the latched value, not the pins
// R04: bits six and seven read zero in all three when not port pins
// R05: bit six is digital only in rc-io, internal-io and ext-clock-io
// R06: bit seven loses digital function in external oscillator modes
// R07: in cycle-output modes bit six drives clock/4 whatever direction
// R08: analog-selected pin has its digital input path disabled
// R09: analog selection leaves the output driver under latch and dir
// R10: after reset analog-capable pins come up as analog inputs
// R11: software keeps direction set on pins used as analog inputs
// R12: capture and encoder inputs on bits 2-4 blocked while analog
// R13: an enabled sharing peripheral takes the pin away from gpio
// R14: unimplemented bits read zero and ignore writes
// R15: analog selects five to eight exist only on the large package
// R16: analog-selected pin reads zero in the pin level register
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pagam_port_a
  import pagam_pkg::*;
#(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    ce,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [PAGAM_ADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [7:0]              pin_in,
  output logic      [7:0]              pin_out,
  output logic      [7:0]              pin_oe_n,
  output logic                         capture_input_one,
  output logic                         capture_input_two,
  output logic                         capture_input_three,
  output logic                         encoder_index_input,
  output logic                         encoder_phase_a_input,
  output logic                         encoder_phase_b_input,
  output logic      [8:0]              analog_select
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0]             latch;
    logic [7:0]             dir;
    logic [7:0]             ans_low;
    logic                   ans_high;
    pagam_osc_type          osc;
    logic [2:0]             claim;
    logic [PAGAM_DIV_W-1:0] div;
    logic [31:0]            rdata;
    logic                   rerr;
    logic                   armed;
    logic [7:0]             pout;
    logic [7:0]             poe_n;
    logic [2:0]             feed;
  } pagam_state_type;

  localparam logic [7:0] ANS_LO_IMPL =
    LARGE_PACKAGE ? PAGAM_ANS_LARGE : PAGAM_ANS_SMALL;
  localparam logic       ANS_HI_IMPL = LARGE_PACKAGE;

  pagam_state_type st_reg;
  pagam_state_type st_next;
  logic [7:0]      pin_sync;
  logic [31:0]     rd_val;
  logic            addr_ok;
  logic [7:0]      io_mask;
  logic [7:0]      ana_pins;
  logic [7:0]      drive;

  // ****************************************
  // helper functions
  // ****************************************
  function automatic logic bit6_io(input pagam_osc_type m);
    bit6_io = (m == PAGAM_OSC_RESISTOR_CAP_IO) ||
              (m == PAGAM_OSC_INTERNAL_IO) ||
              (m == PAGAM_OSC_EXT_CLOCK_IO);
  endfunction

  function automatic logic bit7_io(input pagam_osc_type m);
    bit7_io = (m == PAGAM_OSC_INTERNAL_IO) ||
              (m == PAGAM_OSC_INTERNAL_CYCLE_OUT);
  endfunction

  function automatic logic cyc_out(input pagam_osc_type m);
    cyc_out = (m == PAGAM_OSC_RC_CYCLE_OUT) ||
              (m == PAGAM_OSC_INTERNAL_CYCLE_OUT) ||
              (m == PAGAM_OSC_EXT_CLOCK_CYCLE_OUT);
  endfunction

  // pins usable as gpio under the given oscillator mode
  function automatic logic [7:0] pins_io(input pagam_osc_type m);
    pins_io = PAGAM_LOW_PINS;
    if (bit6_io(m)) begin
      pins_io = pins_io | PAGAM_BIT6;
    end
    if (bit7_io(m)) begin
      pins_io = pins_io | PAGAM_BIT7;
    end
  endfunction

  // ****************************************
  // pin input synchroniser
  // ****************************************
  pagam_sync #(
    .W (8)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   (pin_in),
    .q   (pin_sync)
  );

  // ****************************************
  // pin muxing
  // ****************************************
  always_comb begin
    io_mask  = pins_io(st_reg.osc);
    // only pins 0-5 carry analog channels
    ana_pins = st_reg.ans_low & PAGAM_LOW_PINS;
    // analog select does not touch the driver; see R09
    drive    = ~st_reg.dir & io_mask;  // see R01 R05 R06
    // claimed pins belong to the capture/encoder logic; see R13
    drive[4:2] = drive[4:2] & ~st_reg.claim;
    // cycle clock overrides direction; see R07
    if (cyc_out(st_reg.osc)) begin
      drive[6] = 1'b1;
    end
  end

  // ****************************************
  // register decode and read mux
  // ****************************************
  always_comb begin
    addr_ok = 1'b1;
    rd_val  = '0;  // see R14
    if (paddr == PAGAM_PINS_OFF) begin
      rd_val[7:0] = pin_sync & io_mask & ~ana_pins;  // see R02 R04 R08 R16
    end else if (paddr == PAGAM_LATCH_OFF) begin
      rd_val[7:0] = st_reg.latch & io_mask;  // see R03 R04
    end else if (paddr == PAGAM_DIR_OFF) begin
      rd_val[7:0] = st_reg.dir & io_mask;  // see R04
    end else if (paddr == PAGAM_ANS_LO_OFF) begin
      rd_val[7:0] = st_reg.ans_low;
    end else if (paddr == PAGAM_ANS_HI_OFF) begin
      rd_val[0] = st_reg.ans_high;
    end else if (paddr == PAGAM_OSC_OFF) begin
      rd_val[PAGAM_OSC_W-1:0] = st_reg.osc;
    end else if (paddr == PAGAM_CLAIM_OFF) begin
      rd_val[PAGAM_CLAIM_LSB+2:PAGAM_CLAIM_LSB] = st_reg.claim;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    if (ce) begin
      st_next.div = st_reg.div + 1'b1;
      // capture once per transfer; late if ce was low during setup
      if (psel && !(penable && st_reg.armed)) begin
        st_next.rdata = pwrite ? '0 : rd_val;
        st_next.rerr  = !addr_ok;
        st_next.armed = 1'b1;
      end
      if (psel && penable && st_reg.armed) begin
        st_next.armed = 1'b0;
      end
      // writes land only at the completing access edge
      if (psel && penable && st_reg.armed && pwrite && !st_reg.rerr
          && pstrb[0]) begin
        if (paddr == PAGAM_PINS_OFF) begin
          st_next.latch = pwdata[7:0];  // see R02
        end else if (paddr == PAGAM_LATCH_OFF) begin
          st_next.latch = pwdata[7:0];  // see R03
        end else if (paddr == PAGAM_DIR_OFF) begin
          st_next.dir = pwdata[7:0];
        end else if (paddr == PAGAM_ANS_LO_OFF) begin
          st_next.ans_low = pwdata[7:0] & ANS_LO_IMPL;  // see R14 R15
        end else if (paddr == PAGAM_ANS_HI_OFF) begin
          st_next.ans_high = pwdata[0] & ANS_HI_IMPL;  // see R14 R15
        end else if (paddr == PAGAM_OSC_OFF) begin
          st_next.osc = pagam_osc_type'(pwdata[PAGAM_OSC_W-1:0]);
        end else if (paddr == PAGAM_CLAIM_OFF) begin
          st_next.claim = pwdata[PAGAM_CLAIM_LSB+2:PAGAM_CLAIM_LSB];
        end
      end
      // registered pin drivers
      st_next.pout    = st_reg.latch;  // see R01
      if (cyc_out(st_reg.osc)) begin
        st_next.pout[6] = st_reg.div[PAGAM_DIV_W-1];  // see R07
      end
      st_next.poe_n   = ~drive;
      // peripheral inputs gated by claim and analog; see R12 R13
      st_next.feed    = pin_sync[4:2] & ~ana_pins[4:2] & st_reg.claim;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg          <= '0;
      st_reg.latch    <= PAGAM_LATCH_RST;
      st_reg.dir      <= PAGAM_DIR_RST;
      st_reg.ans_low  <= PAGAM_ANS_LO_RST & ANS_LO_IMPL;  // see R10 R15
      st_reg.ans_high <= PAGAM_ANS_HI_RST & ANS_HI_IMPL;  // see R10
      st_reg.osc      <= PAGAM_OSC_RST;
      st_reg.claim    <= PAGAM_CLAIM_RST;
      st_reg.poe_n    <= 8'hff;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // frozen clock enable stalls the bus rather than losing a transfer
  // ready only once the transfer has been captured on a live edge
  assign pready                = ce && (st_reg.armed || !penable);
  assign pslverr               = psel && penable && st_reg.armed
                                 && st_reg.rerr;
  assign prdata                = st_reg.rdata;
  assign pin_out               = st_reg.pout;
  assign pin_oe_n              = st_reg.poe_n;
  assign capture_input_one     = st_reg.feed[0];
  assign encoder_index_input   = st_reg.feed[0];
  assign capture_input_two     = st_reg.feed[1];
  assign encoder_phase_a_input = st_reg.feed[1];
  assign capture_input_three   = st_reg.feed[2];
  assign encoder_phase_b_input = st_reg.feed[2];
  assign analog_select         = {st_reg.ans_high, st_reg.ans_low};

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic rd_setup;
  logic wr_done;
  assign rd_setup = ce && psel && !penable && !pwrite;
  assign wr_done  = ce && psel && penable && st_reg.armed && pwrite
                    && pstrb[0];

  dir_drive_a: // see R01
    assert property (ce && !st_reg.dir[0] |=>
                     !pin_oe_n[0] && pin_out[0] == $past(st_reg.latch[0]))
    else $error("output pin not driven from latch");

  dir_float_a: // see R01
    assert property (ce && st_reg.dir[1] |=> pin_oe_n[1])
    else $error("input pin is driven");

  pins_write_a: // see R02
    assert property (wr_done && !st_reg.rerr && paddr == PAGAM_PINS_OFF |=>
                     st_reg.latch == $past(pwdata[7:0]))
    else $error("pin register write missed the latch");

  latch_read_a: // see R03
    assert property (rd_setup && paddr == PAGAM_LATCH_OFF
                     && bit7_io(st_reg.osc) && bit6_io(st_reg.osc) |=>
                     prdata[7:0] == $past(st_reg.latch))
    else $error("latch read does not return latch");

  high_zero_a: // see R04
    assert property (rd_setup && paddr == PAGAM_DIR_OFF
                     && !bit7_io(st_reg.osc) |=> prdata[7] == 1'b0)
    else $error("bit seven visible while not a port pin");

  bit6_osc_a: // see R05
    assert property (ce && !bit6_io(st_reg.osc) && !cyc_out(st_reg.osc)
                     |=> pin_oe_n[6])
    else $error("bit six driven in oscillator mode");

  bit7_osc_a: // see R06
    assert property (ce && !bit7_io(st_reg.osc) |=> pin_oe_n[7])
    else $error("bit seven driven in external oscillator mode");

  cyc_drive_a: // see R07
    assert property (ce && cyc_out(st_reg.osc) |=> !pin_oe_n[6]
                     && pin_out[6] == $past(st_reg.div[PAGAM_DIV_W-1]))
    else $error("cycle clock not on bit six");

  cyc_period_a: // see R07
    assert property ($rose(st_reg.div[PAGAM_DIV_W-1]) ##0 ce[*4] |=>
                     $rose(st_reg.div[PAGAM_DIV_W-1]))
    else $error("cycle clock period is not four");

  analog_read_a: // see R08
    assert property (rd_setup && paddr == PAGAM_PINS_OFF
                     && st_reg.ans_low[0] |=> prdata[0] == 1'b0)
    else $error("analog pin read as digital");

  analog_drive_a: // see R09
    assert property (ce && st_reg.ans_low[3] && !st_reg.dir[3]
                     && !st_reg.claim[1] |=> !pin_oe_n[3])
    else $error("analog select killed the driver");

  reset_analog_a: // see R10
    assert property ($past(rst) |-> st_reg.ans_low == (ANS_LO_IMPL)
                     && st_reg.dir == PAGAM_DIR_RST)
    else $error("analog pins not analog after reset");

  cap_block_a: // see R12
    assert property (ce && st_reg.ans_low[2] |=> !capture_input_one
                     && !encoder_index_input)
    else $error("capture input passes on analog pin");

  claim_pin_a: // see R13
    assert property (ce && st_reg.claim[2] |=> pin_oe_n[4])
    else $error("claimed pin still driven by gpio");

  unimpl_zero_a: // see R14
    assert property (rd_setup && paddr == PAGAM_ANS_HI_OFF |=>
                     prdata[31:1] == '0)
    else $error("unimplemented bits read nonzero");

  small_pkg_a: // see R15
    assert property (!LARGE_PACKAGE |-> st_reg.ans_low[7:5] == 3'b000
                     && !st_reg.ans_high)
    else $error("large package selects present");

endmodule
`default_nettype wire

// ### common/pagam_pkg.sv
// Purpose: shared constants and types for the port A GPIO block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   all offsets are byte addresses
package pagam_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int          PAGAM_ADDR_W      = 8;
  localparam logic [7:0]  PAGAM_PINS_OFF    = 8'h00;
  localparam logic [7:0]  PAGAM_LATCH_OFF   = 8'h04;
  localparam logic [7:0]  PAGAM_DIR_OFF     = 8'h08;
  localparam logic [7:0]  PAGAM_ANS_LO_OFF  = 8'h0c;
  localparam logic [7:0]  PAGAM_ANS_HI_OFF  = 8'h10;
  localparam logic [7:0]  PAGAM_OSC_OFF     = 8'h14;
  localparam logic [7:0]  PAGAM_CLAIM_OFF   = 8'h18;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0]  PAGAM_LATCH_RST   = 8'h00;
  localparam logic [7:0]  PAGAM_DIR_RST     = 8'hff;
  localparam logic [7:0]  PAGAM_ANS_LO_RST  = 8'hff;
  localparam logic        PAGAM_ANS_HI_RST  = 1'b1;
  localparam logic [2:0]  PAGAM_CLAIM_RST   = 3'b000;

  // ****************************************
  // field positions and masks
  // ****************************************
  localparam int          PAGAM_OSC_W       = 4;
  localparam int          PAGAM_CLAIM_LSB   = 2;
  localparam logic [7:0]  PAGAM_ANS_SMALL   = 8'h1f;
  localparam logic [7:0]  PAGAM_ANS_LARGE   = 8'hff;
  localparam logic [7:0]  PAGAM_LOW_PINS    = 8'h3f;
  localparam logic [7:0]  PAGAM_BIT6        = 8'h40;
  localparam logic [7:0]  PAGAM_BIT7        = 8'h80;

  // ****************************************
  // cycle clock: one quarter of the core clock
  // ****************************************
  localparam int          PAGAM_CYC_DIV     = 4;
  localparam int          PAGAM_DIV_W       = $clog2(PAGAM_CYC_DIV);

  // ****************************************
  // oscillator configurations
  // ****************************************
  typedef enum logic [PAGAM_OSC_W-1:0] {
    PAGAM_OSC_LP,
    PAGAM_OSC_XT,
    PAGAM_OSC_HS,
    PAGAM_OSC_HSPLL,
    PAGAM_OSC_RC_CYCLE_OUT,
    PAGAM_OSC_RESISTOR_CAP_IO,
    PAGAM_OSC_INTERNAL_CYCLE_OUT,
    PAGAM_OSC_INTERNAL_IO,
    PAGAM_OSC_EXT_CLOCK_CYCLE_OUT,
    PAGAM_OSC_EXT_CLOCK_IO
  } pagam_osc_type;

  localparam pagam_osc_type PAGAM_OSC_RST = PAGAM_OSC_INTERNAL_IO;

endpackage

// ### hw/pagam_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs are asynchronous to clk
// Notes:   output follows once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pagam_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } pagam_sync_state_type;

  pagam_sync_state_type st_reg;
  pagam_sync_state_type st_next;

  // first stage feeds only the second
  always_comb begin
    st_next = st_reg;
    if (ce) begin
      st_next.s1 = d;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      for (int i = 0; i < W; i++) begin
        if (st_reg.s2[i] == st_reg.s3[i]) begin
          st_next.q[i] = st_reg.s3[i];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.q;

endmodule
`default_nettype wire

// ### verif/pagam_pin_model.sv
// Purpose: board side of the port a pins
// Assumes: no pull resistors on any pin
// Notes:   released, undriven pins toggle every cycle, so the synchroniser holds its last agreed level for them
`timescale 1ns/1ps
`default_nettype none
module pagam_pin_model (
  input  wire logic       clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] pin_in
);
  logic [7:0] drift_reg = 8'h55;

  // ****************************************
  // pin resolution
  // ****************************************
  always @(posedge clk) begin
    drift_reg <= ~drift_reg;
  end

  // device drive wins; board drives only released pins
  assign pin_in = (~pin_oe_n & pin_out)
                | (pin_oe_n & ext_en & ext_val)
                | (pin_oe_n & ~ext_en & drift_reg);
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Purpose: self-checking bench for the port a block
// Assumes: apb master waits on pready; ce dropped only in the stall test
// Notes:   waits of 8 cover the pin synchroniser and driver lag
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pagam_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'hf;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        last_err;
  logic [7:0]  pin_in;
  logic [7:0]  pin_out;
  logic [7:0]  pin_oe_n;
  logic [7:0]  ext_val = 8'h3f;
  logic [7:0]  ext_en = 8'hff;
  logic [5:0]  feeds;
  logic [8:0]  analog_select;
  int          errors = 0;
  int          compares = 0;

  always #5 clk = ~clk;

  pagam_port_a dut_u (
    .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .capture_input_one(feeds[5]), .capture_input_two(feeds[4]),
    .capture_input_three(feeds[3]), .encoder_index_input(feeds[2]),
    .encoder_phase_a_input(feeds[1]), .encoder_phase_b_input(feeds[0]),
    .analog_select(analog_select)
  );

  pagam_pin_model pin_u (
    .clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in)
  );

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic stop_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string s);
    logic [31:0] r;
    apb(1'b0, a, 32'h0000_0000, r);
    chk(r, e, s);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rd(PAGAM_LATCH_OFF, {24'h0, PAGAM_LATCH_RST}, "latch rst");
    rd(PAGAM_DIR_OFF, {24'h0, PAGAM_DIR_RST}, "dir rst");
    rd(PAGAM_ANS_LO_OFF, {24'h0, PAGAM_ANS_LO_RST}, "ans lo");
    rd(PAGAM_ANS_HI_OFF, {31'h0, PAGAM_ANS_HI_RST}, "ans hi");
    rd(PAGAM_PINS_OFF, 32'h0000_0000, "pins analog");
    chk({24'h0, pin_oe_n}, 32'h0000_00ff, "oe rst");
    chk({23'h0, analog_select}, 32'h0000_01ff, "ans out");
  endtask

  task automatic t_digital();
    wr(PAGAM_ANS_LO_OFF, 32'h0000_0000);
    wr(PAGAM_DIR_OFF, 32'h0000_00cf);
    ext_val <= 8'h4a;
    wr(PAGAM_PINS_OFF, 32'h0000_0031);
    repeat (8) @(posedge clk);
    rd(PAGAM_LATCH_OFF, 32'h0000_0031, "latch back");
    rd(PAGAM_PINS_OFF, 32'h0000_007a, "pin levels");
    chk({24'h0, pin_oe_n}, 32'h0000_00cf, "oe dir");
    chk({30'h0, pin_out[5:4]}, 32'h0000_0003, "drive");
  endtask

  task automatic t_osc();
    int          m;
    logic [7:0]  k;
    logic        i6;
    logic        i7;
    logic        cy;
    logic        p;
    logic [31:0] hi;
    logic [31:0] ch;
    wr(PAGAM_DIR_OFF, 32'h0000_0000);
    wr(PAGAM_LATCH_OFF, 32'h0000_00c0);
    ext_en <= 8'h00;
    for (m = 0; m < 10; m++) begin
      i6 = (m == 5 || m == 7 || m == 9);
      i7 = (m == 6 || m == 7);
      cy = (m == 4 || m == 6 || m == 8);
      k = {i7, i6, 6'h00};
      wr(PAGAM_OSC_OFF, 32'(m));
      repeat (8) @(posedge clk);
      rd(PAGAM_DIR_OFF, 32'h0000_0000, "osc dir");
      rd(PAGAM_LATCH_OFF, {24'h0, k}, "osc latch");
      rd(PAGAM_PINS_OFF, {24'h0, k}, "osc pins");
      chk({24'h0, pin_oe_n}, {24'h0, ~i7, ~(i6 | cy), 6'h00}, "osc oe");
      if (cy) begin
        hi = 0;
        ch = 0;
        p = pin_out[6];
        repeat (8) begin
          @(posedge clk);
          hi += pin_out[6];
          ch += (pin_out[6] !== p);
          p = pin_out[6];
        end
        chk(hi, 32'h0000_0004, "cyc high");
        chk(ch, 32'h0000_0004, "cyc edges");
      end
    end
    wr(PAGAM_OSC_OFF, 32'h0000_0007);
    ext_en <= 8'hff;
  endtask

  task automatic t_analog();
    ext_val <= 8'h1c;
    wr(PAGAM_DIR_OFF, 32'h0000_00ef);
    wr(PAGAM_CLAIM_OFF, 32'h0000_001c);
    repeat (8) @(posedge clk);
    chk({26'h0, feeds}, 32'h0000_003f, "feeds on");
    chk({24'h0, pin_oe_n}, 32'h0000_00ff, "claim oe");
    rd(PAGAM_PINS_OFF, 32'h0000_001c, "digital in");
    wr(PAGAM_DIR_OFF, 32'h0000_00ee);
    wr(PAGAM_LATCH_OFF, 32'h0000_0001);
    wr(PAGAM_ANS_LO_OFF, 32'h0000_001d);
    repeat (8) @(posedge clk);
    chk({26'h0, feeds}, 32'h0000_0000, "feeds off");
    chk({24'h0, pin_oe_n}, 32'h0000_00fe, "analog oe");
    chk({31'h0, pin_out[0]}, 32'h0000_0001, "analog drive");
    rd(PAGAM_PINS_OFF, 32'h0000_0000, "analog in");
    chk({23'h0, analog_select}, 32'h0000_011d, "ans out");
  endtask

  task automatic t_unimpl();
    wr(PAGAM_LATCH_OFF, 32'hffff_ff5a);
    rd(PAGAM_LATCH_OFF, 32'h0000_005a, "upper bits");
    wr(PAGAM_ANS_HI_OFF, 32'hffff_fffe);
    rd(PAGAM_ANS_HI_OFF, 32'h0000_0000, "ans hi");
    wr(PAGAM_ANS_HI_OFF, 32'h0000_0001);
    rd(PAGAM_ANS_HI_OFF, 32'h0000_0001, "ans hi set");
    rd(8'h1c, 32'h0000_0000, "unmapped");
    chk({31'h0, last_err}, 32'h0000_0001, "unmapped err");
  endtask

  // ce low across setup: the transfer must stall, not be lost
  task automatic t_stall();
    fork
      wr(PAGAM_LATCH_OFF, 32'h0000_003c);
      begin
        ce <= 1'b0;
        repeat (4) @(posedge clk);
        ce <= 1'b1;
      end
    join
    fork
      rd(PAGAM_LATCH_OFF, 32'h0000_003c, "stalled read");
      begin
        ce <= 1'b0;
        repeat (4) @(posedge clk);
        ce <= 1'b1;
      end
    join
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_digital();
    t_osc();
    t_analog();
    t_unimpl();
    t_stall();
    stop_test();
  end

  initial begin
    #100_000;
    errors++;
    stop_test();
  end
endmodule
`default_nettype wire
